// >>> rtl/timer_a_channel_counter.sv
// one 16-bit timer a channel with avalon-mm register slave
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/100ps
// Function
// RQ1: two-bit mode field picks timer, event counter, one-shot or pwm; one-shot and pwm leave the counter idle here.
// RQ2: timer mode counts one of five prescaled internal clocks.
// RQ3: timer mode counts down, reloads on underflow, keeps running.
// RQ4: timer mode divides by n plus one.
// RQ5: run bit starts counting, clearing it halts counting.
// RQ6: interrupt pulse on every underflow or overflow.
// RQ7: count register read returns the live counter.
// RQ8: write before first count pulse loads reload and counter.
// RQ9: write after first count pulse loads reload only.
// RQ10: gate function lets input pin level enable counting.
// RQ11: timer pulse output toggles on underflow, low when stopped.
// RQ12: event source is pin edge, timer b2, or neighbour channel.
// RQ13: single-phase direction from software bit or output pin level.
// RQ14: event overflow or underflow reloads, unless free-run.
// RQ15: event ratio up is ffff minus n plus one, down n plus one.
// RQ16: event pulse output toggles on wrap, low when stopped.
// RQ17: two-phase counting only on channels two to four.
// RQ18: normal two-phase counts input edges while output phase high.
// RQ19: multiply-by-4 counts up on all edges in forward phase.
// RQ20: multiply-by-4 counts down on all edges in reverse phase.
// RQ21: channel three selects processing, two normal, four times four.
// RQ22: channel three clears counter on index pulse in two-phase.
// RQ23: encoder holds each phase level at least one sample period.
module timer_a_channel_counter #(
    parameter int CHANNEL = 3
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [3:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    input wire logic subclk_i,
    input wire logic channel_input_pin_i,
    input wire logic channel_output_pin_i,
    output logic channel_output_pin_o,
    output logic channel_output_pin_oe_o,
    input wire logic index_pulse_i,
    input wire logic tb2_wrap_i,
    input wire logic prev_wrap_i,
    input wire logic next_wrap_i,
    output logic wrap_o,
    output logic irq_o
);
    typedef struct packed {
        logic [timer_a_pkg::MODE_W-1:0] mode;
        logic run;
        logic started;
        logic [15:0] cnt;
        logic [15:0] reload;
        logic [4:0] div;
        logic sub_prev;
        logic [4:0] sub_div;
        logic in_prev;
        logic out_prev;
        logic idx_prev;
        logic pulse;
        logic irq;
        logic ack;
        logic [31:0] rdata;
    } state_t;

    localparam bit HAS_TWO_PHASE = (CHANNEL >= 2) && (CHANNEL <= 4);
    localparam bit HAS_X4_SEL = (CHANNEL == 3);
    localparam bit FIXED_X4 = (CHANNEL == 4);

    state_t s_q;
    state_t s_d;
    logic [1:0] rst_sync_q;
    logic rst_n;

    // release of the async reset is retimed to the system clock
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    logic [1:0] mode_f;
    logic [2:0] clk_f;
    logic [1:0] src_f;
    logic two_phase;
    logic use_x4;
    logic pre_strobe;
    logic gate_ok;
    logic timer_tick;
    logic step_up;
    logic step_dn;
    logic index_clear;
    logic req_new;
    logic req_done;

    assign mode_f = s_q.mode[timer_a_pkg::MODE_MSB:timer_a_pkg::MODE_LSB];
    assign clk_f = s_q.mode[timer_a_pkg::CLK_MSB:timer_a_pkg::CLK_LSB];
    assign src_f = s_q.mode[timer_a_pkg::SRC_MSB:timer_a_pkg::SRC_LSB];
    // RQ17 two-phase gated
    assign two_phase = HAS_TWO_PHASE && s_q.mode[timer_a_pkg::TWO_PHASE_BIT];
    // RQ21 fixed processing
    assign use_x4 = FIXED_X4 || (HAS_X4_SEL && s_q.mode[timer_a_pkg::X4_BIT]);
    assign req_new = (read_i || write_i) && !s_q.ack;
    assign req_done = (read_i || write_i) && s_q.ack;

    // RQ2 prescaler select
    always_comb begin
        pre_strobe = 1'b0;
        unique case (clk_f)
            timer_a_pkg::CLK_DIV1: pre_strobe = 1'b1;
            timer_a_pkg::CLK_DIV2:
                pre_strobe = (s_q.div & timer_a_pkg::PRE_MASK2) ==
                             timer_a_pkg::PRE_MASK2;
            timer_a_pkg::CLK_DIV8:
                pre_strobe = (s_q.div & timer_a_pkg::PRE_MASK8) ==
                             timer_a_pkg::PRE_MASK8;
            timer_a_pkg::CLK_DIV32:
                pre_strobe = s_q.div == timer_a_pkg::PRE_MASK32;
            timer_a_pkg::CLK_SUB32:
                pre_strobe = subclk_i && !s_q.sub_prev &&
                             s_q.sub_div == timer_a_pkg::PRE_MASK32;
            default: pre_strobe = 1'b0;
        endcase
    end

    // RQ10 gate level
    assign gate_ok = !s_q.mode[timer_a_pkg::GATE_EN_BIT] ||
                     (channel_input_pin_i ==
                      s_q.mode[timer_a_pkg::GATE_LVL_BIT]);
    assign timer_tick = s_q.run && mode_f == timer_a_pkg::MODE_TIMER &&
                        gate_ok && pre_strobe;
    // RQ22 index clear
    assign index_clear = HAS_X4_SEL && s_q.run && two_phase &&
                         mode_f == timer_a_pkg::MODE_EVENT &&
                         s_q.mode[timer_a_pkg::INDEX_EN_BIT] &&
                         index_pulse_i && !s_q.idx_prev;

    // event counting steps
    always_comb begin
        logic in_rise;
        logic in_fall;
        logic in_chg;
        logic out_chg;
        logic src_ev;
        logic up;
        in_rise = channel_input_pin_i && !s_q.in_prev;
        in_fall = !channel_input_pin_i && s_q.in_prev;
        in_chg = in_rise || in_fall;
        out_chg = channel_output_pin_i != s_q.out_prev;
        src_ev = 1'b0;
        up = 1'b0;
        step_up = 1'b0;
        step_dn = 1'b0;
        if (s_q.run && mode_f == timer_a_pkg::MODE_EVENT) begin
            if (two_phase) begin
                if (use_x4) begin
                    // RQ19 forward quadrature
                    if (in_chg != out_chg) begin
                        up = channel_input_pin_i == s_q.out_prev;
                        step_up = up;
                        // RQ20 reverse quadrature
                        step_dn = !up;
                    end
                end else begin
                    // RQ18 normal two-phase
                    step_up = in_rise && channel_output_pin_i;
                    step_dn = in_fall && channel_output_pin_i;
                end
            end else begin
                // RQ12 source select
                unique case (src_f)
                    timer_a_pkg::SRC_PIN:
                        src_ev = s_q.mode[timer_a_pkg::EDGE_RISE_BIT] ?
                                 in_rise : in_fall;
                    timer_a_pkg::SRC_TB2: src_ev = tb2_wrap_i;
                    timer_a_pkg::SRC_PREV: src_ev = prev_wrap_i;
                    timer_a_pkg::SRC_NEXT: src_ev = next_wrap_i;
                endcase
                // RQ13 direction select
                up = s_q.mode[timer_a_pkg::DIR_PIN_BIT] ?
                     channel_output_pin_i : s_q.mode[timer_a_pkg::SW_UP_BIT];
                step_up = src_ev && up;
                step_dn = src_ev && !up;
            end
        end
    end

    always_comb begin
        logic [31:0] wd;
        logic [31:0] rd;
        logic free;
        wd = 32'h0000_0000;
        rd = 32'h0000_0000;
        free = s_q.mode[timer_a_pkg::FREE_RUN_BIT];
        s_d = s_q;
        s_d.irq = 1'b0;
        s_d.ack = req_new;
        s_d.div = s_q.div + 5'h01;
        s_d.sub_prev = subclk_i;
        if (subclk_i && !s_q.sub_prev) begin
            s_d.sub_div = s_q.sub_div + 5'h01;
        end
        s_d.in_prev = channel_input_pin_i;
        s_d.out_prev = channel_output_pin_i;
        s_d.idx_prev = index_pulse_i;

        if (timer_tick) begin
            s_d.started = 1'b1;
            // RQ3 RQ4 down count with reload
            if (s_q.cnt == timer_a_pkg::COUNT_MIN) begin
                s_d.cnt = s_q.reload;
                // RQ6 underflow request
                s_d.irq = 1'b1;
                // RQ11 toggle on underflow
                s_d.pulse = !s_q.pulse;
            end else begin
                s_d.cnt = s_q.cnt - 16'h0001;
            end
        end else if (step_up) begin
            s_d.started = 1'b1;
            // RQ14 RQ15 overflow reload or wrap
            if (s_q.cnt == timer_a_pkg::COUNT_MAX) begin
                s_d.cnt = free ? timer_a_pkg::COUNT_MIN : s_q.reload;
                // RQ6 overflow request
                s_d.irq = 1'b1;
                // RQ16 toggle on wrap
                s_d.pulse = !s_q.pulse;
            end else begin
                s_d.cnt = s_q.cnt + 16'h0001;
            end
        end else if (step_dn) begin
            s_d.started = 1'b1;
            // RQ14 RQ15 underflow reload or wrap
            if (s_q.cnt == timer_a_pkg::COUNT_MIN) begin
                s_d.cnt = free ? timer_a_pkg::COUNT_MAX : s_q.reload;
                s_d.irq = 1'b1;
                s_d.pulse = !s_q.pulse;
            end else begin
                s_d.cnt = s_q.cnt - 16'h0001;
            end
        end
        if (index_clear) begin
            s_d.cnt = timer_a_pkg::COUNT_MIN;
        end

        // RQ7 live count readback
        unique case (address_i)
            timer_a_pkg::MODE_OFS: rd[timer_a_pkg::MODE_W-1:0] = s_q.mode;
            timer_a_pkg::RUN_OFS: rd[CHANNEL] = s_q.run;
            timer_a_pkg::COUNT_OFS: rd[15:0] = s_q.cnt;
            timer_a_pkg::STAT_OFS: rd[1:0] = {s_q.pulse, s_q.started};
            default: rd = 32'h0000_0000;
        endcase
        if (req_new && read_i) begin
            s_d.rdata = rd;
        end

        if (req_done && write_i) begin
            unique case (address_i)
                timer_a_pkg::MODE_OFS: begin
                    wd = merge({15'h0000, s_q.mode}, writedata_i,
                               byteenable_i);
                    // RQ1 mode field
                    s_d.mode = wd[timer_a_pkg::MODE_W-1:0];
                end
                timer_a_pkg::RUN_OFS: begin
                    wd = merge({31'h0000_0000, s_q.run} << CHANNEL,
                               writedata_i, byteenable_i);
                    // RQ5 run control
                    s_d.run = wd[CHANNEL];
                end
                timer_a_pkg::COUNT_OFS: begin
                    wd = merge({16'h0000, s_q.reload}, writedata_i,
                               byteenable_i);
                    // RQ9 reload always written
                    s_d.reload = wd[15:0];
                    // RQ8 counter written before first pulse
                    if (!s_q.run || !s_q.started) begin
                        s_d.cnt = wd[15:0];
                    end
                end
                default: wd = 32'h0000_0000;
            endcase
        end
        // RQ5 RQ11 RQ16 stopped state
        if (!s_d.run) begin
            s_d.started = 1'b0;
            s_d.pulse = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{mode: timer_a_pkg::MODE_RST,
                     cnt: timer_a_pkg::COUNT_RST,
                     reload: timer_a_pkg::COUNT_RST,
                     rdata: 32'h0000_0000,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // the slave always inserts exactly one wait cycle
    assign waitrequest_o = req_new;
    assign readdata_o = s_q.rdata;
    assign irq_o = s_q.irq;
    assign wrap_o = s_q.irq;
    assign channel_output_pin_o = s_q.pulse;
    // pin is an input when used for direction or as a phase
    assign channel_output_pin_oe_o = s_q.mode[timer_a_pkg::PULSE_EN_BIT] &&
        !two_phase &&
        !(mode_f == timer_a_pkg::MODE_EVENT &&
          s_q.mode[timer_a_pkg::DIR_PIN_BIT]);

    // RQ1 pwm mode holds
    idle_mode_hold_a: assert property (  // RQ1
        @(posedge clk_sys_i) disable iff (!rst_n)
        (mode_f == timer_a_pkg::MODE_PWM && !(req_done && write_i))
        |=> $stable(s_q.cnt))
        else $error("counter moved in an unimplemented mode");
    // RQ2 div8 strobe
    div8_strobe_a: assert property (  // RQ2
        @(posedge clk_sys_i) disable iff (!rst_n)
        (timer_tick && clk_f == timer_a_pkg::CLK_DIV8)
        |-> s_q.div[2:0] == 3'h7)
        else $error("div8 tick off its prescaler phase");
    // RQ3 reload on underflow
    underflow_reload_a: assert property (  // RQ3
        @(posedge clk_sys_i) disable iff (!rst_n)
        (timer_tick && s_q.cnt == 16'h0000 && !(req_done && write_i))
        |=> s_q.cnt == $past(s_q.reload) && irq_o)
        else $error("underflow did not reload");
    // RQ5 stopped counter stable
    stopped_stable_a: assert property (  // RQ5
        @(posedge clk_sys_i) disable iff (!rst_n)
        (!s_q.run && !(req_done && write_i)) |=> $stable(s_q.cnt))
        else $error("stopped counter changed");
    // RQ6 irq cause
    irq_cause_a: assert property (  // RQ6
        @(posedge clk_sys_i) disable iff (!rst_n)
        irq_o |-> $past(s_q.cnt) == 16'h0000 || $past(s_q.cnt) == 16'hffff)
        else $error("interrupt without a wrap");
    // RQ8 write while stopped
    stopped_write_a: assert property (  // RQ8
        @(posedge clk_sys_i) disable iff (!rst_n)
        (req_done && write_i && address_i == timer_a_pkg::COUNT_OFS &&
         byteenable_i == 4'hf && !s_q.run)
        |=> s_q.cnt == $past(writedata_i[15:0]) &&
            s_q.reload == $past(writedata_i[15:0]))
        else $error("stopped write did not load counter");
    // RQ9 running write
    running_write_a: assert property (  // RQ9
        @(posedge clk_sys_i) disable iff (!rst_n)
        (req_done && write_i && address_i == timer_a_pkg::COUNT_OFS &&
         s_q.run && s_q.started && !timer_tick && !step_up && !step_dn &&
         !index_clear)
        |=> $stable(s_q.cnt))
        else $error("running write touched the counter");
    // RQ11 low when stopped
    stopped_low_a: assert property (  // RQ11
        @(posedge clk_sys_i) disable iff (!rst_n)
        !s_q.run |-> !channel_output_pin_o)
        else $error("pulse output high while stopped");
    // RQ22 index clear
    index_zero_a: assert property (  // RQ22
        @(posedge clk_sys_i) disable iff (!rst_n)
        (index_clear && !(req_done && write_i)) |=> s_q.cnt == 16'h0000)
        else $error("index pulse did not clear counter");
    // bus answers after one wait cycle
    bus_answer_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n)
        (req_new && $stable(address_i)) |=> !waitrequest_o)
        else $error("slave wait state longer than one cycle");
endmodule // timer_a_channel_counter

// >>> rtl/timer_a_pkg.sv
// constants shared by the timer a channel counter
package timer_a_pkg;
    // register byte offsets on the avalon slave
    localparam logic [3:0] MODE_OFS = 4'h0;
    localparam logic [3:0] RUN_OFS = 4'h4;
    localparam logic [3:0] COUNT_OFS = 4'h8;
    localparam logic [3:0] STAT_OFS = 4'hc;
    // channel mode register layout
    localparam int MODE_W = 17;
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 1;
    localparam int PULSE_EN_BIT = 2;
    localparam int GATE_EN_BIT = 3;
    localparam int GATE_LVL_BIT = 4;
    localparam int EDGE_RISE_BIT = 5;
    localparam int SW_UP_BIT = 6;
    localparam int DIR_PIN_BIT = 7;
    localparam int SRC_LSB = 8;
    localparam int SRC_MSB = 9;
    localparam int FREE_RUN_BIT = 10;
    localparam int TWO_PHASE_BIT = 11;
    localparam int X4_BIT = 12;
    localparam int INDEX_EN_BIT = 13;
    localparam int CLK_LSB = 14;
    localparam int CLK_MSB = 16;
    localparam logic [MODE_W-1:0] MODE_RST = 17'h00000;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_MIN = 16'h0000;
    // operating modes in the two-bit mode field
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_ONESHOT = 2'h2;
    localparam logic [1:0] MODE_PWM = 2'h3;
    // event sources
    localparam logic [1:0] SRC_PIN = 2'h0;
    localparam logic [1:0] SRC_TB2 = 2'h1;
    localparam logic [1:0] SRC_PREV = 2'h2;
    localparam logic [1:0] SRC_NEXT = 2'h3;
    // prescaled clock selects
    localparam logic [2:0] CLK_DIV1 = 3'h0;
    localparam logic [2:0] CLK_DIV2 = 3'h1;
    localparam logic [2:0] CLK_DIV8 = 3'h2;
    localparam logic [2:0] CLK_DIV32 = 3'h3;
    localparam logic [2:0] CLK_SUB32 = 3'h4;
    // prescaler masks, strobe when all masked bits are one
    localparam logic [4:0] PRE_MASK2 = 5'h01;
    localparam logic [4:0] PRE_MASK8 = 5'h07;
    localparam logic [4:0] PRE_MASK32 = 5'h1f;
    localparam int CLK_HZ = 10000000;
endpackage

// >>> test/quad_src_model.sv
// encoder phases, edge and wrap pulses and free sub-clock at the far side
`timescale 1ns/100ps
module quad_src_model (
    input wire logic clk_i,
    output logic in_pin_o,
    output logic phase_b_o,
    output logic index_o,
    output logic [2:0] wrap_o,
    output logic subclk_o
);
    logic [1:0] sub_q = 2'h0;
    initial begin
        in_pin_o = 1'b0;
        phase_b_o = 1'b0;
        index_o = 1'b0;
        wrap_o = 3'h0;
    end
    // sub-clock runs free, one rising edge every four cycles
    always @(posedge clk_i) begin
        sub_q <= sub_q + 2'h1;
    end
    assign subclk_o = sub_q[1];
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic set_pins(input logic a, input logic b);
        @(posedge clk_i);
        in_pin_o <= a;
        phase_b_o <= b;
        hold(1);
    endtask
    task automatic edge_pulse();
        set_pins(1'b1, phase_b_o);
        set_pins(1'b0, phase_b_o);
    endtask
    // bit 0 timer b2, bit 1 previous, bit 2 next channel
    task automatic wrap(input int s);
        @(posedge clk_i);
        wrap_o <= 3'h1 << s;
        @(posedge clk_i);
        wrap_o <= 3'h0;
        hold(1);
    endtask
    // forward: output phase leads the input phase
    task automatic quad(input bit fwd, input int n);
        repeat (n) begin
            if (fwd) begin
                set_pins(1'b0, 1'b1);
                set_pins(1'b1, 1'b1);
                set_pins(1'b1, 1'b0);
            end else begin
                set_pins(1'b1, 1'b0);
                set_pins(1'b1, 1'b1);
                set_pins(1'b0, 1'b1);
            end
            set_pins(1'b0, 1'b0);
        end
    endtask
    task automatic index_pulse();
        @(posedge clk_i);
        index_o <= 1'b1;
        hold(2);
        index_o <= 1'b0;
    endtask
endmodule // quad_src_model

// >>> test/timer_a_channel_counter_tb.sv
// register-level bench for the timer a channel counter
`timescale 1ns/100ps
module timer_a_channel_counter_tb;
    localparam int CH = 3;
    localparam logic [31:0] RUN = 32'h1 << CH;
    localparam logic [3:0] CNT = timer_a_pkg::COUNT_OFS;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] readdata, c1;
    logic waitreq, pin_o, pin_oe, in_pin, phase_b, index, subclk, irq, p1;
    logic [2:0] wraps;
    logic wrap;
    logic irq_pin;
    int n_errors = 0;
    int n_tests = 0;
    int irq_cnt = 0;
    int wrap_cnt = 0;
    int since = 0;
    int per = 0;
    int cyc = 0;
    int i0, base;
    int divs [5] = '{1, 2, 8, 32, 128};
    // output pin is an input whenever the channel does not drive it
    wire out_lvl = pin_oe ? pin_o : phase_b;

    timer_a_channel_counter #(.CHANNEL(CH)) u_timer_a_channel_counter (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .address_i(address),
        .read_i(read), .write_i(write), .writedata_i(wdata),
        .byteenable_i(4'hf), .readdata_o(readdata), .waitrequest_o(waitreq),
        .subclk_i(subclk), .channel_input_pin_i(in_pin),
        .channel_output_pin_i(out_lvl), .channel_output_pin_o(pin_o),
        .channel_output_pin_oe_o(pin_oe), .index_pulse_i(index),
        .tb2_wrap_i(wraps[0]), .prev_wrap_i(wraps[1]),
        .next_wrap_i(wraps[2]), .wrap_o(wrap), .irq_o(irq));
    quad_src_model u_quad_src_model (.clk_i(clk_sys_i), .in_pin_o(in_pin),
        .phase_b_o(phase_b), .index_o(index), .wrap_o(wraps),
        .subclk_o(subclk));

    always #50 clk_sys_i = ~clk_sys_i;

    // irq count and spacing between the last two requests
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        since <= (irq === 1'b1) ? 1 : since + 1;
        if (irq === 1'b1) begin
            per <= since;
            irq_cnt <= irq_cnt + 1;
            // pin is settled here, it changed with the request
            irq_pin <= pin_o;
        end
        if (wrap === 1'b1) begin
            wrap_cnt <= wrap_cnt + 1;
        end
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clk_sys_i);
        address <= a;
        wdata <= d;
        write <= w;
        read <= !w;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (waitreq !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (k >= 20) check("bus wait", 1, 0);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] t;
        bus(1'b1, a, d, t);
    endtask
    task automatic rd_chk(input string n, input logic [3:0] a,
                          input logic [31:0] e);
        logic [31:0] t;
        bus(1'b0, a, 32'h0, t);
        check(n, t, e);
    endtask
    task automatic wait_irq(input int lim);
        int s, k;
        s = irq_cnt;
        k = 0;
        while (irq_cnt == s && k < lim) begin
            @(posedge clk_sys_i);
            k++;
        end
        if (k >= lim) check("irq wait", 1, 0);
    endtask
    // stop, program mode and count while stopped, then start
    task automatic arm(input logic [31:0] m, input logic [15:0] c);
        wr(timer_a_pkg::RUN_OFS, 32'h0);
        wr(timer_a_pkg::MODE_OFS, m);
        wr(CNT, {16'h0, c});
        wr(timer_a_pkg::RUN_OFS, RUN);
    endtask
    function automatic logic [31:0] fb(input int b);
        return 32'h1 << b;
    endfunction

    initial begin
        tick(5);
        nrst_i <= 1'b1;
        tick(3);
        rd_chk("mode reset", timer_a_pkg::MODE_OFS, 32'h0);
        rd_chk("count reset", CNT, 32'h0);
        wr(4'h6, 32'hffffffff);
        rd_chk("unmapped", 4'h6, 32'h0);
        for (i0 = 2; i0 < 4; i0++) begin
            arm(32'(i0), 16'h0005);
            tick(20);
            rd_chk("idle mode", CNT, 32'h5);
        end
        for (i0 = 0; i0 < 5; i0++) begin
            arm(fb(timer_a_pkg::PULSE_EN_BIT) |
                (32'(i0) << timer_a_pkg::CLK_LSB), 16'h0001);
            wait_irq(600);
            p1 = ~irq_pin;
            wait_irq(600);
            check("timer period", per, 2 * divs[i0]);
            check("pulse toggle", irq_pin, p1);
        end
        wr(timer_a_pkg::RUN_OFS, 32'h0);
        tick(2);
        check("pulse idle", pin_o, 0);
        // new count lands only at the following underflow
        arm(32'h0, 16'h0009);
        wait_irq(50);
        wr(CNT, 32'h2);
        wait_irq(50);
        check("old reload", per, 10);
        wait_irq(50);
        check("new reload", per, 3);
        wr(timer_a_pkg::RUN_OFS, 32'h0);
        bus(1'b0, CNT, 32'h0, c1);
        tick(5);
        rd_chk("halted", CNT, c1);
        arm(fb(timer_a_pkg::GATE_EN_BIT) | fb(timer_a_pkg::GATE_LVL_BIT),
            16'h0064);
        tick(10);
        rd_chk("gate closed", CNT, 32'h64);
        u_quad_src_model.set_pins(1'b1, 1'b0);
        tick(10);
        bus(1'b0, CNT, 32'h0, c1);
        check("gate open", c1 < 32'h64, 1);
        u_quad_src_model.set_pins(1'b0, 1'b0);
        arm(timer_a_pkg::MODE_EVENT | fb(timer_a_pkg::EDGE_RISE_BIT) |
            fb(timer_a_pkg::SW_UP_BIT), 16'hfffd);
        base = irq_cnt;
        u_quad_src_model.edge_pulse();
        u_quad_src_model.edge_pulse();
        rd_chk("up count", CNT, 32'hffff);
        u_quad_src_model.edge_pulse();
        tick(2);
        rd_chk("overflow reload", CNT, 32'hfffd);
        check("overflow irq", irq_cnt - base, 1);
        arm(timer_a_pkg::MODE_EVENT, 16'h0005);
        u_quad_src_model.set_pins(1'b1, 1'b0);
        rd_chk("rise ignored", CNT, 32'h5);
        u_quad_src_model.set_pins(1'b0, 1'b0);
        rd_chk("fall counted", CNT, 32'h4);
        for (i0 = 1; i0 < 4; i0++) begin
            arm(timer_a_pkg::MODE_EVENT | fb(timer_a_pkg::PULSE_EN_BIT) |
                (32'(i0) << timer_a_pkg::SRC_LSB), 16'h0001);
            u_quad_src_model.wrap(i0 % 3);
            u_quad_src_model.wrap(i0 - 1);
            rd_chk("source count", CNT, 32'h0);
            base = irq_cnt;
            u_quad_src_model.wrap(i0 - 1);
            tick(2);
            rd_chk("underflow reload", CNT, 32'h1);
            check("wrap pulse out", pin_o, 1);
            check("underflow irq", irq_cnt - base, 1);
        end
        wr(timer_a_pkg::RUN_OFS, 32'h0);
        tick(2);
        check("event pulse idle", pin_o, 0);
        arm(timer_a_pkg::MODE_EVENT | fb(timer_a_pkg::FREE_RUN_BIT) |
            (32'h1 << timer_a_pkg::SRC_LSB), 16'h0000);
        u_quad_src_model.wrap(0);
        rd_chk("free run", CNT, 32'hffff);
        arm(timer_a_pkg::MODE_EVENT | fb(timer_a_pkg::DIR_PIN_BIT) |
            (32'h1 << timer_a_pkg::SRC_LSB), 16'h000a);
        u_quad_src_model.set_pins(1'b0, 1'b1);
        u_quad_src_model.wrap(0);
        bus(1'b0, CNT, 32'h0, c1);
        u_quad_src_model.set_pins(1'b0, 1'b0);
        u_quad_src_model.wrap(0);
        check("dir counted", c1, 32'hb);
        rd_chk("dir reversed", CNT, 32'ha);
        arm(timer_a_pkg::MODE_EVENT | fb(timer_a_pkg::TWO_PHASE_BIT),
            16'h0064);
        u_quad_src_model.quad(1'b1, 3);
        rd_chk("normal up", CNT, 32'h67);
        u_quad_src_model.quad(1'b0, 1);
        rd_chk("normal down", CNT, 32'h66);
        check("phase pin input", pin_oe, 0);
        arm(timer_a_pkg::MODE_EVENT | fb(timer_a_pkg::TWO_PHASE_BIT) |
            fb(timer_a_pkg::X4_BIT) | fb(timer_a_pkg::INDEX_EN_BIT),
            16'h0064);
        u_quad_src_model.quad(1'b1, 2);
        rd_chk("x4 up", CNT, 32'h6c);
        u_quad_src_model.quad(1'b0, 1);
        rd_chk("x4 down", CNT, 32'h68);
        u_quad_src_model.index_pulse();
        rd_chk("index clear", CNT, 32'h0);
        check("wrap count", wrap_cnt, irq_cnt);
        final_report();
    end
endmodule // timer_a_channel_counter_tb
